/* mifu_defines.svh */
// Purpose: named constants of the upper identification field bank
// Assumes: included by the package, the field table and the top module file
// Notes: offsets are word indices; the byte address is four times the index
`ifndef MIFU_DEFINES_SVH
`define MIFU_DEFINES_SVH

// ----------------------------------------------------------------------
// bus geometry
// ----------------------------------------------------------------------
`define MIFU_ADDR_W 12
`define MIFU_DATA_W 32
`define MIFU_IDX_W 10
`define MIFU_TABLE_N 49

// ----------------------------------------------------------------------
// identification byte indices (word index, byte address is index * 4)
// ----------------------------------------------------------------------
`define MIFU_IDX_FIRST 10'h08E
`define MIFU_IDX_LAST 10'h0BE
`define MIFU_IDX_SMF 10'h08E
`define MIFU_IDX_OM3 10'h08F
`define MIFU_IDX_OM2 10'h090
`define MIFU_IDX_OM1 10'h091
`define MIFU_IDX_CABLE 10'h092
`define MIFU_IDX_TECH 10'h093
`define MIFU_IDX_NAME 10'h094
`define MIFU_IDX_EXT 10'h0A4
`define MIFU_IDX_OUI 10'h0A5
`define MIFU_IDX_PN 10'h0A8
`define MIFU_IDX_REV 10'h0B8
`define MIFU_IDX_WL 10'h0BA
`define MIFU_IDX_TOL 10'h0BC
`define MIFU_IDX_TEMP 10'h0BE

// ----------------------------------------------------------------------
// local control, status and check registers (word index)
// ----------------------------------------------------------------------
`define MIFU_IDX_CTRL 10'h100
`define MIFU_IDX_STAT 10'h101
`define MIFU_IDX_CHECK 10'h102
`define MIFU_CTRL_ERRW_BIT 0
`define MIFU_CTRL_CLR_BIT 1

// ----------------------------------------------------------------------
// field lengths and encodings
// ----------------------------------------------------------------------
`define MIFU_NAME_N 16
`define MIFU_OUI_N 3
`define MIFU_PN_N 16
`define MIFU_REV_N 2
`define MIFU_ASCII_SPACE 8'h20
`define MIFU_LEN_MIN 8'h01
`define MIFU_LEN_SAT 8'hFF
`define MIFU_CABLE_MAX_DM 16'h09EC
`define MIFU_DM_PER_M 16'h000A
`define MIFU_COPPER_FIRST 4'hA
`define MIFU_CNT_MAX 8'hFF
`define MIFU_CNT_ONE 8'h01

`endif

/* mifu_pkg.sv */
// Purpose: shared types of the upper identification field bank
// Assumes: constants come from mifu_defines.svh
// Notes: the technology enum follows the code order 0000b..1111b
`include "mifu_defines.svh"

package mifu_pkg;

   typedef logic [7:0] mifu_byte_t;
   typedef logic [`MIFU_TABLE_N-1:0][7:0] mifu_table_t;

   // transmitter technology codes in upper nibble order
   typedef enum logic [3:0] {
      MIFU_TX_VCSEL_850, MIFU_TX_VCSEL_1310, MIFU_TX_VCSEL_1550, MIFU_TX_FP_1310,
      MIFU_TX_DFB_1310, MIFU_TX_DFB_1550, MIFU_TX_EML_1310, MIFU_TX_EML_1550,
      MIFU_TX_OTHERS, MIFU_TX_DFB_1490, MIFU_TX_CU_UNEQ, MIFU_TX_CU_PASSIVE_EQ,
      MIFU_TX_CU_NEAR_FAR_EQ, MIFU_TX_CU_FAR_EQ, MIFU_TX_CU_NEAR_EQ, MIFU_TX_CU_LINEAR_EQ
   } mifu_tx_tech_t;

   // complete register state of the top module
   typedef struct packed {
      logic [`MIFU_DATA_W-1:0] rdata;
      logic ready;
      logic slverr;
      logic errOnWrite;
      logic [7:0] rejectCount;
      logic [7:0] lastRejectIndex;
   } mifu_state_t;

endpackage

/* mifu_field_table.sv */
// Purpose: builds the constant identification byte table from parameters
// Assumes: parameters are fixed at elaboration; no state is held here
// Notes: text fields are given right aligned in the literal and realigned here
`timescale 1ns/1ps
`include "mifu_defines.svh"

module mifu_field_table
   import mifu_pkg::*;
#(
   parameter bit IS_CABLE_ASSEMBLY = 1'b0,
   parameter logic [7:0] SMF_KM = 8'h0A,
   parameter logic [7:0] OM3_2M = 8'h00,
   parameter logic [7:0] OM2_M = 8'h00,
   parameter logic [7:0] OM1_M = 8'h00,
   parameter logic [15:0] CABLE_DM = 16'h0000,
   parameter mifu_tx_tech_t TX_TECH = MIFU_TX_DFB_1310,
   parameter bit WL_CONTROL = 1'b0,
   parameter bit COOLED = 1'b0,
   parameter bit AVALANCHE_PHOTODIODE_DETECTOR = 1'b0,
   parameter bit TUNABLE = 1'b0,
   parameter logic [127:0] MAKER_NAME = "EXAMPLE MAKER",
   parameter logic [2:0] EXT_RATES = 3'h0,
   parameter logic [23:0] ORG_ID = 24'h000000,
   parameter logic [127:0] PART_NUMBER = "PART-0001",
   parameter logic [15:0] REVISION = "A",
   parameter logic [15:0] WAVELENGTH_X20 = 16'h6626,
   parameter logic [7:0] ATTEN_2G5_DB = 8'h00,
   parameter logic [7:0] ATTEN_5G0_DB = 8'h00,
   parameter logic [15:0] TOLERANCE_X200 = 16'h251C,
   parameter logic [7:0] CASE_TEMP_C = 8'h00
) (
   output mifu_table_t tableBytes // byte k sits at index first + k
);

   // ----------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------
   // left align the low n bytes and pad with spaces; all zero stays zero
   function automatic logic [127:0] align_text(input logic [127:0] v, input int n);
      logic [127:0] r;
      int lead;
      bit seen;
      r = '0;
      lead = 0;
      seen = 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         if (!seen && v[i*8+:8] == 8'h00) lead++;
         else seen = 1'b1;
      end
      if (lead < n) begin
         for (int i = n - 1; i >= 0; i--) begin
            r[i*8+:8] = (i - lead >= 0) ? v[(i-lead)*8+:8] : `MIFU_ASCII_SPACE;
         end
      end
      return r;
   endfunction

   // metre code from decimetres; part metres above one are truncated
   function automatic mifu_byte_t cable_code(input logic [15:0] dm);
      logic [15:0] m;
      m = dm / `MIFU_DM_PER_M;
      if (dm == '0) cable_code = '0;
      else if (dm < `MIFU_DM_PER_M) cable_code = `MIFU_LEN_MIN;
      else if (dm > `MIFU_CABLE_MAX_DM) cable_code = `MIFU_LEN_SAT;
      else cable_code = m[7:0];
   endfunction

   function automatic int pos(input logic [`MIFU_IDX_W-1:0] idx);
      return int'(idx - `MIFU_IDX_FIRST);
   endfunction

   // ----------------------------------------------------------------------
   // table assembly
   // ----------------------------------------------------------------------
   logic isCopper;
   logic [127:0] nameText;
   logic [127:0] pnText;
   logic [127:0] revText;

   assign isCopper = (TX_TECH >= `MIFU_COPPER_FIRST);
   assign nameText = align_text(MAKER_NAME, `MIFU_NAME_N);
   assign pnText = align_text(PART_NUMBER, `MIFU_PN_N);
   assign revText = align_text({112'h0, REVISION}, `MIFU_REV_N);

   // each field written in address order, high byte at the lower address
   always_comb begin
      tableBytes = '0;
      tableBytes[pos(`MIFU_IDX_SMF)] = IS_CABLE_ASSEMBLY ? '0 : SMF_KM;
      tableBytes[pos(`MIFU_IDX_OM3)] = IS_CABLE_ASSEMBLY ? '0 : OM3_2M;
      tableBytes[pos(`MIFU_IDX_OM2)] = IS_CABLE_ASSEMBLY ? '0 : OM2_M;
      tableBytes[pos(`MIFU_IDX_OM1)] = IS_CABLE_ASSEMBLY ? '0 : OM1_M;
      tableBytes[pos(`MIFU_IDX_CABLE)] = cable_code(CABLE_DM);
      tableBytes[pos(`MIFU_IDX_TECH)] = {TX_TECH, WL_CONTROL, COOLED, AVALANCHE_PHOTODIODE_DETECTOR, TUNABLE};
      for (int k = 0; k < `MIFU_NAME_N; k++) begin
         tableBytes[pos(`MIFU_IDX_NAME) + k] = nameText[(`MIFU_NAME_N-1-k)*8+:8];
      end
      tableBytes[pos(`MIFU_IDX_EXT)] = {5'h00, EXT_RATES};
      for (int k = 0; k < `MIFU_OUI_N; k++) begin
         tableBytes[pos(`MIFU_IDX_OUI) + k] = ORG_ID[(`MIFU_OUI_N-1-k)*8+:8];
      end
      for (int k = 0; k < `MIFU_PN_N; k++) begin
         tableBytes[pos(`MIFU_IDX_PN) + k] = pnText[(`MIFU_PN_N-1-k)*8+:8];
      end
      for (int k = 0; k < `MIFU_REV_N; k++) begin
         tableBytes[pos(`MIFU_IDX_REV) + k] = revText[(`MIFU_REV_N-1-k)*8+:8];
      end
      // copper reuses the wavelength pair for attenuation
      tableBytes[pos(`MIFU_IDX_WL)] = isCopper ? ATTEN_2G5_DB : WAVELENGTH_X20[15:8];
      tableBytes[pos(`MIFU_IDX_WL)+1] = isCopper ? ATTEN_5G0_DB : WAVELENGTH_X20[7:0];
      tableBytes[pos(`MIFU_IDX_TOL)] = IS_CABLE_ASSEMBLY ? '0 : TOLERANCE_X200[15:8];
      tableBytes[pos(`MIFU_IDX_TOL)+1] = IS_CABLE_ASSEMBLY ? '0 : TOLERANCE_X200[7:0];
      tableBytes[pos(`MIFU_IDX_TEMP)] = CASE_TEMP_C;
   end

endmodule

/* mifu_id_fields_upper.sv */
// Purpose: read-only identification bytes 142..190 of a four-lane module on APB
// Assumes: APB master on core_clk; one word per byte index, data in bits 7:0
// Notes: answer comes one cycle after the access phase starts
//
// Contract
// - single-mode length byte in kilometres; zero means unsupported or inferred.
// - all four fibre length bytes read zero for any cable assembly.
// - extended-bandwidth 50 micron length in two-metre units; zero unsupported.
// - 50 micron and 62.5 micron lengths in one-metre units; zero unsupported.
// - cable length in metres; below one metre reads one; zero not a cable.
// - cable length code 255 means longer than 254 metres.
// - technology byte: transmitter code in bits 7-4, device flags in 3-0.
// - flags: wavelength control, cooled, avalanche detector, tunable; clear means not.
// - codes 0000b-0111b and 1001b lasers, 1000b others, 1010b-1111b copper variants.
// - maker name is sixteen ASCII bytes, left aligned, space padded.
// - maker name or organisation identifier must hold valid content.
// - compliance byte bits 0-2 single/double/quad rate; bits 7-3 zero.
// - organisation identifier is three bytes; all zero means unspecified.
// - part number sixteen ASCII bytes, left aligned, space padded; zero unspecified.
// - revision two ASCII bytes, left aligned, space padded; zero unspecified.
// - optical wavelength is 16-bit nanometres times twenty, high byte first.
// - copper uses the pair for attenuation at 2.5 and 5.0 GHz.
// - tolerance 16-bit nanometres times two hundred, high first; zero for cables.
// - controlled-wavelength parts report the centre of the guaranteed range.
// - case temperature limit in degrees Celsius; zero means seventy.
// - base check byte is low eight bits of sum of bytes 128..190.
`timescale 1ns/1ps
`include "mifu_defines.svh"

module mifu_id_fields_upper
   import mifu_pkg::*;
#(
   parameter bit IS_CABLE_ASSEMBLY = 1'b0,
   parameter logic [7:0] SMF_KM = 8'h0A,
   parameter logic [7:0] OM3_2M = 8'h00,
   parameter logic [7:0] OM2_M = 8'h00,
   parameter logic [7:0] OM1_M = 8'h00,
   parameter logic [15:0] CABLE_DM = 16'h0000,
   parameter mifu_tx_tech_t TX_TECH = MIFU_TX_DFB_1310,
   parameter bit WL_CONTROL = 1'b0,
   parameter bit COOLED = 1'b0,
   parameter bit AVALANCHE_PHOTODIODE_DETECTOR = 1'b0,
   parameter bit TUNABLE = 1'b0,
   parameter logic [127:0] MAKER_NAME = "EXAMPLE MAKER",
   parameter logic [2:0] EXT_RATES = 3'h0,
   parameter logic [23:0] ORG_ID = 24'h000000, // arbitrary neutral value
   parameter logic [127:0] PART_NUMBER = "PART-0001",
   parameter logic [15:0] REVISION = "A",
   parameter logic [15:0] WAVELENGTH_X20 = 16'h6626,
   parameter logic [7:0] ATTEN_2G5_DB = 8'h00,
   parameter logic [7:0] ATTEN_5G0_DB = 8'h00,
   parameter logic [15:0] TOLERANCE_X200 = 16'h251C,
   parameter logic [7:0] CASE_TEMP_C = 8'h00,
   parameter logic [7:0] LOW_BYTES_SUM = 8'h00 // sum of bytes 128..141, mod 256
) (
   input wire logic core_clk, // system clock, 50 MHz
   input wire logic rst, // synchronous reset, active high
   input wire logic psel, // APB select
   input wire logic penable, // APB access phase
   input wire logic pwrite, // APB direction, high for write
   input wire logic [`MIFU_ADDR_W-1:0] paddr, // APB byte address
   input wire logic [`MIFU_DATA_W-1:0] pwdata, // APB write data
   input wire logic [3:0] pstrb, // APB byte strobes
   output logic [`MIFU_DATA_W-1:0] prdata, // APB read data, registered
   output logic pready, // APB ready, registered
   output logic pslverr // APB error, registered
);

   // ----------------------------------------------------------------------
   // constant identification table
   // ----------------------------------------------------------------------
   mifu_table_t tableBytes;

   // the wavelength parameter should hold the range centre for tuned parts
   mifu_field_table #(
      .IS_CABLE_ASSEMBLY(IS_CABLE_ASSEMBLY),
      .SMF_KM(SMF_KM),
      .OM3_2M(OM3_2M),
      .OM2_M(OM2_M),
      .OM1_M(OM1_M),
      .CABLE_DM(CABLE_DM),
      .TX_TECH(TX_TECH),
      .WL_CONTROL(WL_CONTROL),
      .COOLED(COOLED),
      .AVALANCHE_PHOTODIODE_DETECTOR(AVALANCHE_PHOTODIODE_DETECTOR),
      .TUNABLE(TUNABLE),
      .MAKER_NAME(MAKER_NAME),
      .EXT_RATES(EXT_RATES),
      .ORG_ID(ORG_ID),
      .PART_NUMBER(PART_NUMBER),
      .REVISION(REVISION),
      .WAVELENGTH_X20(WAVELENGTH_X20),
      .ATTEN_2G5_DB(ATTEN_2G5_DB),
      .ATTEN_5G0_DB(ATTEN_5G0_DB),
      .TOLERANCE_X200(TOLERANCE_X200),
      .CASE_TEMP_C(CASE_TEMP_C)
   ) u_table (
      .tableBytes(tableBytes)
   );

   // ----------------------------------------------------------------------
   // helper functions
   // ----------------------------------------------------------------------
   // true when the word index falls inside the identification range
   function automatic logic is_id_index(input logic [`MIFU_IDX_W-1:0] idx);
      return (idx >= `MIFU_IDX_FIRST) && (idx <= `MIFU_IDX_LAST);
   endfunction

   // table byte for an index already known to be inside the range
   function automatic mifu_byte_t id_byte(input mifu_table_t t,
                                          input logic [`MIFU_IDX_W-1:0] idx);
      logic [`MIFU_IDX_W-1:0] k;
      k = idx - `MIFU_IDX_FIRST;
      return t[k[5:0]];
   endfunction

   // true when n bytes starting at an index are all zero
   function automatic logic field_zero(input mifu_table_t t,
                                       input logic [`MIFU_IDX_W-1:0] idx,
                                       input int n);
      logic z;
      logic [`MIFU_IDX_W-1:0] k;
      z = 1'b1;
      k = idx - `MIFU_IDX_FIRST;
      for (int i = 0; i < n; i++) begin
         if (t[int'(k) + i] != 8'h00) z = 1'b0;
      end
      return z;
   endfunction

   // ----------------------------------------------------------------------
   // check sum and field validity
   // ----------------------------------------------------------------------
   logic [7:0] rangeSum;
   logic [7:0] baseCheckByte;
   logic nameValid;
   logic ouiSpecified;
   logic pnSpecified;
   logic revSpecified;
   logic identityOk;

   // modulo-256 sum of every byte of this range
   always_comb begin
      rangeSum = '0;
      for (int k = 0; k < `MIFU_TABLE_N; k++) begin
         rangeSum = rangeSum + tableBytes[k];
      end
   end

   // the lower bytes live elsewhere; only their sum is brought in
   assign baseCheckByte = rangeSum + LOW_BYTES_SUM;

   // field status, for software to spot a badly built table
   assign nameValid = !field_zero(tableBytes, `MIFU_IDX_NAME, `MIFU_NAME_N);
   assign ouiSpecified = !field_zero(tableBytes, `MIFU_IDX_OUI, `MIFU_OUI_N);
   assign pnSpecified = !field_zero(tableBytes, `MIFU_IDX_PN, `MIFU_PN_N);
   assign revSpecified = !field_zero(tableBytes, `MIFU_IDX_REV, `MIFU_REV_N);
   assign identityOk = nameValid | ouiSpecified;

   // ----------------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------------
   logic [`MIFU_IDX_W-1:0] wordIdx;
   logic aligned;
   logic [`MIFU_DATA_W-1:0] statusWord;
   logic [`MIFU_DATA_W-1:0] checkWord;
   logic [`MIFU_DATA_W-1:0] ctrlWord;
   // registered state and its next value, declared ahead of the read views
   mifu_state_t s_q;
   mifu_state_t s_d;

   assign wordIdx = paddr[`MIFU_ADDR_W-1:2];
   assign aligned = (paddr[1:0] == 2'h0);

   // read views of the local registers, unused bits read zero
   assign statusWord = {8'h00, s_q.lastRejectIndex, 3'h0, identityOk, revSpecified,
                        pnSpecified, ouiSpecified, nameValid, s_q.rejectCount};
   assign checkWord = {16'h0000, baseCheckByte, rangeSum};
   assign ctrlWord = {31'h00000000, s_q.errOnWrite};

   // ----------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------
   logic accessPhase;
   logic completeEdge;
   logic idHit;

   // two steps: first access cycle loads the answer, the ready edge commits
   always_comb begin
      s_d = s_q;
      accessPhase = psel & penable & ~s_q.ready;
      completeEdge = psel & penable & s_q.ready;
      idHit = aligned && is_id_index(wordIdx);
      s_d.ready = accessPhase;

      // answer: data and error held until the next access phase loads a new one
      if (accessPhase) begin
         s_d.rdata = '0;
         s_d.slverr = 1'b0;
         if (!aligned) begin
            s_d.slverr = 1'b1;
         end else if (idHit) begin
            if (pwrite) s_d.slverr = s_q.errOnWrite;
            else s_d.rdata = {24'h000000, id_byte(tableBytes, wordIdx)};
         end else if (wordIdx == `MIFU_IDX_CTRL) begin
            if (!pwrite) s_d.rdata = ctrlWord;
         end else if (wordIdx == `MIFU_IDX_STAT) begin
            if (!pwrite) s_d.rdata = statusWord;
         end else if (wordIdx == `MIFU_IDX_CHECK) begin
            if (!pwrite) s_d.rdata = checkWord;
         end else begin
            s_d.slverr = 1'b1;
         end
      end

      // write effects land only on the edge where pready is seen high
      if (completeEdge && pwrite && aligned) begin
         if (wordIdx == `MIFU_IDX_CTRL && pstrb[0]) begin
            s_d.errOnWrite = pwdata[`MIFU_CTRL_ERRW_BIT];
            if (pwdata[`MIFU_CTRL_CLR_BIT]) begin
               s_d.rejectCount = '0;
               s_d.lastRejectIndex = '0;
            end
         end
         // table bytes stay as they are; the attempt is counted and its index kept
         if (idHit) begin
            s_d.lastRejectIndex = wordIdx[7:0];
            if (s_d.rejectCount != `MIFU_CNT_MAX) begin
               s_d.rejectCount = s_d.rejectCount + `MIFU_CNT_ONE;
            end
         end
      end
   end

   // single register stage for all state
   always_ff @(posedge core_clk) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------------
   assign prdata = s_q.rdata;
   assign pready = s_q.ready;
   assign pslverr = s_q.slverr;

endmodule

/* mifu_id_fields_upper_checker.sv */
// Purpose: port-level timing and map checks of the identification bank
// Assumes: one clock domain, synchronous active-high reset
// Notes: attached by bind; only the top module's ports are seen
`timescale 1ns/1ps

module mifu_id_fields_upper_checker (
   input wire logic core_clk, // clock
   input wire logic rst, // reset
   input wire logic psel, // select
   input wire logic penable, // access phase
   input wire logic pwrite, // direction
   input wire logic [11:0] paddr, // byte address
   input wire logic [31:0] pwdata, // write data
   input wire logic [3:0] pstrb, // strobes
   input wire logic [31:0] prdata, // read data
   input wire logic pready, // ready
   input wire logic pslverr // error
);
   logic isId;
   logic isLocal;
   // ----------------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------------
   // mirrors the map, aligned words only
   assign isId = paddr[1:0] == 2'h0 && paddr[11:2] >= 10'h08E && paddr[11:2] <= 10'h0BE;
   assign isLocal = paddr[1:0] == 2'h0 && paddr[11:2] >= 10'h100 && paddr[11:2] <= 10'h102;
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   // ----------------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------------
   AST_ANSWER_NEXT: assert property (psel && penable && !pready |=> pready)
      else $error("answer missing one cycle after access");
   AST_READY_ONE: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   AST_NO_STRAY: assert property (!(psel && penable) |=> !pready)
      else $error("ready without access");
   AST_RESET_QUIET: assert property ($fell(rst) |-> !pready && !pslverr && prdata == 32'h0)
      else $error("outputs not cleared by reset");
   AST_BYTE_WIDE: assert property (pready && !pwrite && isId |-> !pslverr && prdata[31:8] == 24'h0)
      else $error("identification read not a clean byte");
   AST_UNALIGNED: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr && prdata == 32'h0)
      else $error("unaligned access not refused");
   AST_UNMAPPED: assert property (pready && !isId && !isLocal |-> pslverr)
      else $error("unmapped access not refused");
   AST_HOLD: assert property (!pready && !$past(rst) |-> $stable(prdata) && $stable(pslverr))
      else $error("read data moved between answers");
endmodule

bind mifu_id_fields_upper mifu_id_fields_upper_checker chk (.core_clk(core_clk), .rst(rst),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));

/* mifu_apb_host.sv */
// Purpose: host side bus master reading and writing the bank
// Assumes: slave answers with pready; waits are bounded
// Notes: every bus signal moves by non-blocking assignment after a rising edge; timedOut is set blocking
`timescale 1ns/1ps

module mifu_apb_host (
   input wire logic core_clk, // clock
   output logic psel, // select
   output logic penable, // access phase
   output logic pwrite, // direction
   output logic [11:0] paddr, // byte address
   output logic [31:0] pwdata, // write data
   output logic [3:0] pstrb, // strobes
   input wire logic [31:0] prdata, // read data
   input wire logic pready, // ready
   input wire logic pslverr, // error
   output logic timedOut // last wait ran out
);
   // idle bus at time zero
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      pstrb = 4'hF;
      timedOut = 1'b0;
   end
   // ----------------------------------------------------------------------
   // one transfer: setup, access held until ready is sampled high
   // ----------------------------------------------------------------------
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic e);
      int n;
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 64);
      rd = prdata;
      e = pslverr;
      timedOut = pready !== 1'b1;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule

/* mifu_id_fields_upper_test.sv */
// Purpose: self-checking bench of the identification bank
// Assumes: design answers per its hand-over timing
// Notes: a second copper cable instance shares the bus and is read through its held data
`timescale 1ns/1ps

module mifu_id_fields_upper_test;
   import mifu_pkg::*;
   localparam logic [7:0] LOW_SUM = 8'h11;
   logic core_clk, rst, psel, penable, pwrite, pready, pslverr, timedOut, rerr;
   logic [11:0] paddr, a;
   logic [31:0] pwdata, prdata, rdat, prdata2;
   logic [3:0] pstrb;
   logic [7:0] expByte [0:48];
   logic [7:0] sum;
   logic [127:0] nameTxt, partTxt;
   int fails, cmp_count;

   mifu_id_fields_upper #(.CABLE_DM(16'h0005), .WL_CONTROL(1'b1), .AVALANCHE_PHOTODIODE_DETECTOR(1'b1),
      .EXT_RATES(3'h5), .LOW_BYTES_SUM(LOW_SUM)) dut (.core_clk(core_clk), .rst(rst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   mifu_apb_host host (.core_clk(core_clk), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .timedOut(timedOut));
   // copper cable variant; answers in step with dut, its data holds after the answer
   mifu_id_fields_upper #(.IS_CABLE_ASSEMBLY(1'b1), .CABLE_DM(16'h0A00),
      .TX_TECH(MIFU_TX_CU_UNEQ), .ATTEN_2G5_DB(8'h12), .ATTEN_5G0_DB(8'h34)) dut2 (
      .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata2), .pready(),
      .pslverr());

   // 50 MHz clock
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   // ----------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      cmp_count++;
      if (seen !== want) begin
         fails++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // a hung slave ends the run here
   task automatic acc(input logic w, input logic [11:0] ad, input logic [31:0] d);
      host.xfer(w, ad, d, rdat, rerr);
      // read inside the host: the port copy may not have settled yet
      if (host.timedOut) begin
         fails++;
         print_verdict();
      end
   endtask
   // ----------------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------------
   initial begin
      rst = 1'b1;
      fails = 0;
      cmp_count = 0;
      sum = 8'h00;
      nameTxt = "EXAMPLE MAKER   ";
      partTxt = "PART-0001       ";
      for (int k = 0; k < 49; k++) expByte[k] = 8'h00;
      expByte[0] = 8'h0A;
      expByte[4] = 8'h01; // half a metre rounds up
      expByte[5] = 8'h4A; // code 0100b, wavelength control, avalanche detector
      for (int k = 0; k < 16; k++) begin
         expByte[6 + k] = nameTxt[127 - 8 * k -: 8];
         expByte[26 + k] = partTxt[127 - 8 * k -: 8];
      end
      expByte[22] = 8'h05;
      expByte[42] = 8'h41;
      expByte[43] = 8'h20;
      expByte[44] = 8'h66; // high byte at lower address
      expByte[45] = 8'h26;
      expByte[46] = 8'h25;
      expByte[47] = 8'h1C;
      repeat (20) @(posedge core_clk);
      rst <= 1'b0;
      // every byte reads its constant, then survives a write
      for (int k = 0; k < 49; k++) begin
         a = 12'h238 + 12'(4 * k);
         acc(1'b0, a, 32'h0);
         check(rdat, {24'h0, expByte[k]});
         if (k < 4 || k > 45) check(prdata2, 32'h0);
         if (k == 4) check(prdata2, 32'hFF);
         if (k == 5) check(prdata2, 32'hA0);
         if (k == 44) check(prdata2, 32'h12);
         if (k == 45) check(prdata2, 32'h34);
         sum = sum + expByte[k];
         acc(1'b1, a, 32'hFF);
         check({31'h0, rerr}, 32'h0);
         acc(1'b0, a, 32'h0);
         check(rdat, {24'h0, expByte[k]});
      end
      acc(1'b0, 12'h404, 32'h0);
      check(rdat, 32'h00BE1D31);
      acc(1'b0, 12'h408, 32'h0);
      check(rdat, {16'h0, sum + LOW_SUM, sum});
      // refused write flagged once enabled, then counters cleared
      acc(1'b1, 12'h400, 32'h1);
      acc(1'b0, 12'h400, 32'h0);
      check(rdat, 32'h1);
      acc(1'b1, 12'h2F8, 32'h0);
      check({31'h0, rerr}, 32'h1);
      acc(1'b1, 12'h400, 32'h2);
      acc(1'b0, 12'h404, 32'h0);
      check(rdat & 32'h00FF00FF, 32'h0);
      // misaligned and unmapped places
      acc(1'b0, 12'h239, 32'h0);
      check({rerr, rdat[30:0]}, 32'h80000000);
      acc(1'b0, 12'h300, 32'h0);
      check({31'h0, rerr}, 32'h1);
      print_verdict();
   end
endmodule
